/* src/synth_cfg_pkg.sv */
package synth_cfg_pkg;
    localparam int REG_W = 24;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_DIVIDE_GAIN = 8'h16;
    localparam logic [7:0] IDX_MODES = 8'h17;
    localparam logic [7:0] IDX_BIAS = 8'h18;
    localparam logic [7:0] IDX_CAL = 8'h19;
    localparam logic [7:0] IDX_SEED = 8'h1A;
    localparam logic [23:0] RST_DIVIDE_GAIN = 24'h0006C1;
    localparam logic [23:0] RST_MODES = 24'h0001AB;
    localparam logic [23:0] RST_BIAS = 24'h0054C1;
    localparam logic [23:0] RST_CAL = 24'h000AAA;
    localparam logic [23:0] RST_SEED = 24'hB29D0B;
    localparam logic [5:0] DIV_MAX = 6'h3E;
    localparam logic [5:0] DIV_MUTE = 6'h00;
    localparam logic [5:0] DIV_PASS = 6'h01;
    localparam int POS_MASTER_EN = 0;
    localparam int POS_EXT_BUF_EN = 2;
    localparam int POS_LOOP_BUF_EN = 3;
    localparam int POS_PRI_EN = 4;
    localparam int POS_SEC_EN = 5;
    localparam int POS_EXT_IN_EN = 6;
    localparam int POS_PRELOCK_MUTE = 7;
    localparam int POS_PRI_SE = 8;
    localparam int POS_SEC_SE = 9;
    localparam int POS_PUMP_SEL = 11;
    localparam int POS_DIV_STAGE_GAIN = 10;
    localparam int POS_EXT_BIAS_LO = 19;

    typedef struct packed {
        logic [5:0] divide_ratio;
        logic [1:0] primary_gain;
        logic [1:0] secondary_gain;
        logic div_stage_gain_max;
    } gain_ctl_t;

    typedef struct packed {
        logic subsystem_en;
        logic ext_buf_to_out;
        logic loop_buf_en;
        logic output_stages_on;
        logic primary_out_pos_pin_en;
        logic primary_out_neg_pin_en;
        logic secondary_out_pos_pin_en;
        logic secondary_out_neg_pin_en;
        logic ext_input_en;
        logic pump_output_a_sel;
        logic pump_output_b_sel;
        logic [1:0] ext_bias;
    } path_ctl_t;
endpackage : synth_cfg_pkg

/* src/synth_output_config_regs.sv */
// What this block does
// - divide zero mutes output stages only
// - odd ratios above one round down, above 62 clamps
// - primary gain code 3 max, 3 dB steps
// - secondary gain same mapping, resets to 2
// - divider stage gain bit selects max/-3 dB
// - master enable needs chip enable too
// - external buffer bit routes buffer to output
// - loop buffer bit powers loop buffer, resets one
// - bit four primary, bit five secondary enable
// - bit six enables external input path
// - pre-lock mute holds outputs until lock
// - primary single-ended drives negative pin only
// - secondary single-ended drives one pin only
// - pump select: zero pump a, one pump b
// - seed sets phase as 2pi seed/2^24
// - seed sets start phase, reapplied per change outside exact mode without autoseed
`timescale 1ns/100ps
module synth_output_config_regs
    import synth_cfg_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device status
    input wire logic chip_enable,
    input wire logic loop_locked,
    input wire logic exact_freq_mode,
    input wire logic auto_seed_en,
    input wire logic freq_change,
    // decoded controls
    output gain_ctl_t gain_ctl,
    output path_ctl_t path_ctl,
    output logic [23:0] phase_seed,
    output logic seed_load,
    output logic [23:0] calibration_value
);
    logic rst_s1;
    logic rst_n;
    logic [23:0] divide_gain, modes, bias, cal, seed;
    logic [23:0] next_divide_gain, next_modes, next_bias, next_cal, next_seed;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_seed_load;
    logic seed_pending, next_seed_pending;
    gain_ctl_t next_gain_ctl;
    path_ctl_t next_path_ctl;
    logic [7:0] idx;
    logic hit;
    logic access;
    logic rd_valid, next_rd_valid;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    assign idx = paddr[9:2];
    assign access = psel && penable;
    // one wait state: read data and error are registered before pready rises
    assign pready = access && rd_valid;

    // first access cycle loads read data, second (pready high) commits a write
    always_comb
    begin
        hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
              (idx >= IDX_DIVIDE_GAIN) && (idx <= IDX_SEED);
        next_rd_valid = access && !rd_valid;
        next_divide_gain = divide_gain;
        next_modes = modes;
        next_bias = bias;
        next_cal = cal;
        next_seed = seed;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (access && !rd_valid)
        begin
            next_pslverr = !hit;
            next_prdata = 32'h0;
            if (!pwrite && hit)
            begin
                case (idx)
                    IDX_DIVIDE_GAIN: next_prdata = {8'h00, divide_gain};
                    IDX_MODES: next_prdata = {8'h00, modes};
                    IDX_BIAS: next_prdata = {8'h00, bias};
                    IDX_CAL: next_prdata = {8'h00, cal};
                    IDX_SEED: next_prdata = {8'h00, seed};
                    default: next_prdata = 32'h0;
                endcase
            end
        end
        else if (access && pwrite && hit)
        begin
            case (idx)
                IDX_DIVIDE_GAIN: next_divide_gain = pwdata[23:0];
                IDX_MODES: next_modes = pwdata[23:0];
                IDX_BIAS: next_bias = pwdata[23:0];
                IDX_CAL: next_cal = pwdata[23:0];
                IDX_SEED: next_seed = pwdata[23:0];
                default: next_divide_gain = divide_gain;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divide_gain <= RST_DIVIDE_GAIN;
            modes <= RST_MODES;
            bias <= RST_BIAS;
            cal <= RST_CAL;
            seed <= RST_SEED;
            prdata <= 32'h0;
            pslverr <= 1'b0;
            rd_valid <= 1'b0;
        end
        else
        begin
            divide_gain <= next_divide_gain;
            modes <= next_modes;
            bias <= next_bias;
            cal <= next_cal;
            seed <= next_seed;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            rd_valid <= next_rd_valid;
        end
    end

    // decoded control outputs
    always_comb
    begin
        logic [5:0] raw;
        logic muted;
        logic en;
        muted = 1'b0;
        en = 1'b0;
        raw = divide_gain[5:0];
        next_gain_ctl.divide_ratio = raw;
        if (raw > DIV_MAX)
        begin
            next_gain_ctl.divide_ratio = DIV_MAX;
        end
        else if (raw[0] && (raw != DIV_PASS))
        begin
            next_gain_ctl.divide_ratio = {raw[5:1], 1'b0};
        end
        // one passes through, even values divide by themselves
        next_gain_ctl.primary_gain = divide_gain[7:6];
        next_gain_ctl.secondary_gain = divide_gain[9:8];
        next_gain_ctl.div_stage_gain_max = divide_gain[POS_DIV_STAGE_GAIN];
        en = modes[POS_MASTER_EN] && chip_enable;
        muted = modes[POS_PRELOCK_MUTE] && !loop_locked;
        next_path_ctl.subsystem_en = en;
        next_path_ctl.ext_buf_to_out = en && modes[POS_EXT_BUF_EN];
        next_path_ctl.loop_buf_en = en && modes[POS_LOOP_BUF_EN];
        next_path_ctl.output_stages_on = en && (raw != DIV_MUTE);
        next_path_ctl.primary_out_neg_pin_en = next_path_ctl.output_stages_on &&
            modes[POS_PRI_EN] && !muted;
        next_path_ctl.primary_out_pos_pin_en = next_path_ctl.primary_out_neg_pin_en &&
            !modes[POS_PRI_SE];
        next_path_ctl.secondary_out_pos_pin_en = next_path_ctl.output_stages_on &&
            modes[POS_SEC_EN] && !muted;
        next_path_ctl.secondary_out_neg_pin_en = next_path_ctl.secondary_out_pos_pin_en &&
            !modes[POS_SEC_SE];
        next_path_ctl.ext_input_en = en && modes[POS_EXT_IN_EN];
        next_path_ctl.pump_output_a_sel = !modes[POS_PUMP_SEL];
        next_path_ctl.pump_output_b_sel = modes[POS_PUMP_SEL];
        next_path_ctl.ext_bias = bias[POS_EXT_BIAS_LO +: 2];
    end

    // seed load: in exact mode when seed differs from phase_seed, first use, or each change outside exact mode without autoseed
    always_comb
    begin
        next_seed_pending = seed_pending;
        next_seed_load = 1'b0;
        if (exact_freq_mode)
        begin
            next_seed_load = (seed != phase_seed) || seed_pending;
            next_seed_pending = 1'b0;
        end
        else if (auto_seed_en)
        begin
            next_seed_load = seed_pending;
            next_seed_pending = 1'b0;
        end
        else
        begin
            next_seed_load = freq_change || seed_pending;
            next_seed_pending = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gain_ctl <= '0;
            path_ctl <= '0;
            phase_seed <= RST_SEED;
            seed_load <= 1'b0;
            seed_pending <= 1'b1;
            calibration_value <= RST_CAL;
        end
        else
        begin
            gain_ctl <= next_gain_ctl;
            path_ctl <= next_path_ctl;
            seed_load <= next_seed_load;
            seed_pending <= next_seed_pending;
            if (next_seed_load)
            begin
                phase_seed <= seed;
            end
            calibration_value <= cal;
        end
    end
endmodule : synth_output_config_regs

/* tb/synth_output_config_regs_chk.sv */
`timescale 1ns/100ps
module synth_output_config_regs_chk
    import synth_cfg_pkg::*;
(
    // watched ports
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chip_enable,
    input wire logic exact_freq_mode,
    input wire logic auto_seed_en,
    input wire logic freq_change,
    input wire gain_ctl_t gain_ctl,
    input wire path_ctl_t path_ctl,
    input wire logic seed_load
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic ok;
    logic acc;
    assign ok = paddr[1:0] == 2'h0 && paddr >= 12'h058 && paddr <= 12'h068;
    assign acc = psel && penable;
    a_pready_one_wait: assert property (acc && !pready |=> pready) else $error("pready late");
    a_pready_in_acc: assert property (pready |-> acc) else $error("pready outside access");
    a_bad_addr_err: assert property (acc && pready && !ok |->
        pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
    a_good_addr_ok: assert property (acc && pready && ok |-> !pslverr)
        else $error("mapped refused");
    a_upper_zero: assert property (prdata[31:24] == 8'h00) else $error("prdata top");
    a_pri_single: assert property (path_ctl.primary_out_pos_pin_en |->
        path_ctl.primary_out_neg_pin_en) else $error("primary pin pair");
    a_sec_single: assert property (path_ctl.secondary_out_neg_pin_en |->
        path_ctl.secondary_out_pos_pin_en) else $error("secondary pin pair");
    a_mute_stages: assert property (!path_ctl.output_stages_on |->
        !path_ctl.primary_out_neg_pin_en && !path_ctl.secondary_out_pos_pin_en)
        else $error("pins on while stages off");
    a_subsys_chip: assert property (path_ctl.subsystem_en |-> $past(chip_enable))
        else $error("subsystem without chip enable");
    a_pump_excl: assert property ($past(arst_n, 4) |->
        path_ctl.pump_output_a_sel != path_ctl.pump_output_b_sel) else $error("pump select");
    a_ratio_legal: assert property (gain_ctl.divide_ratio <= DIV_MAX &&
        (!gain_ctl.divide_ratio[0] || gain_ctl.divide_ratio == DIV_PASS)) else $error("ratio");
    a_seed_on_change: assert property (freq_change && !exact_freq_mode && !auto_seed_en
        |=> seed_load) else $error("seed not reloaded");
    c_refused: cover property (acc && !ok);
    c_seed: cover property (seed_load);
    c_muted: cover property ($past(arst_n, 4) && !path_ctl.output_stages_on);
endmodule : synth_output_config_regs_chk

bind synth_output_config_regs synth_output_config_regs_chk u_chk (.core_clk(core_clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_enable(chip_enable),
    .exact_freq_mode(exact_freq_mode), .auto_seed_en(auto_seed_en),
    .freq_change(freq_change), .gain_ctl(gain_ctl), .path_ctl(path_ctl), .seed_load(seed_load));

/* tb/test_synth_output_config_regs.sv */
`timescale 1ns/100ps
module test_synth_output_config_regs
    import synth_cfg_pkg::*;
;
    logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, seed_load, err;
    logic chip_enable, loop_locked, exact_freq_mode, auto_seed_en, freq_change;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] phase_seed, calibration_value;
    gain_ctl_t gain_ctl;
    path_ctl_t path_ctl;
    int n_errors = 0;
    int samples_checked = 0;
    logic [7:0] ix[5] = '{IDX_DIVIDE_GAIN, IDX_MODES, IDX_BIAS, IDX_CAL, IDX_SEED};
    logic [23:0] rs[5] = '{RST_DIVIDE_GAIN, RST_MODES, RST_BIAS, RST_CAL, RST_SEED};
    logic [5:0] rv[7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3D, 6'h3E, 6'h3F};
    logic [5:0] ex[7] = '{6'h00, 6'h01, 6'h02, 6'h02, 6'h3C, 6'h3E, 6'h3E};
    logic [23:0] mv[4] = '{24'h000B5D, 24'h000B5D, 24'h0000B1, 24'h0000B1};
    logic [1:0] cl[4] = '{2'h3, 2'h1, 2'h2, 2'h3};
    logic [13:0] pe[4] = '{14'h1E97, 14'h0007, 14'h120B, 14'h13EB};

    synth_output_config_regs u_dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_enable(chip_enable),
        .loop_locked(loop_locked), .exact_freq_mode(exact_freq_mode),
        .auto_seed_en(auto_seed_en), .freq_change(freq_change), .gain_ctl(gain_ctl),
        .path_ctl(path_ctl), .phase_seed(phase_seed), .seed_load(seed_load),
        .calibration_value(calibration_value));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one apb transfer; read data and error taken in the cycle pready stands high
    task automatic apb(input logic w, input logic [11:0] a, input logic [23:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {8'h00, d};
        @(posedge core_clk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(negedge core_clk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1)
        begin
            n_errors++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [11:0] ra(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ra

    initial
    begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {chip_enable, loop_locked, exact_freq_mode, auto_seed_en, freq_change} = 5'h18;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check("path_rst", 32'(path_ctl), 32'h1668);
        check("gain_rst", 32'(gain_ctl), 32'h03D);
        for (int k = 0; k < 5; k++)
        begin
            apb(1'b0, ra(ix[k]), 24'h0);
            check("reset_value", rd, {8'h00, rs[k]});
            apb(1'b1, ra(ix[k]), ~rs[k]);
            apb(1'b0, ra(ix[k]), 24'h0);
            check("readback", rd, {8'h00, ~rs[k]});
        end
        apb(1'b1, ra(IDX_MODES), RST_MODES);
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, ra(IDX_DIVIDE_GAIN), {13'h0, i[0], ~i[1:0], i[1:0], rv[i]});
            @(posedge core_clk);
            #1;
            check("gain", 32'(gain_ctl), 32'({ex[i], i[1:0], ~i[1:0], i[0]}));
            check("stages", 32'({path_ctl.output_stages_on, path_ctl.secondary_out_pos_pin_en}),
                (rv[i] != 6'h00) ? 32'h3 : 32'h0);
        end
        for (int j = 0; j < 4; j++)
        begin
            @(posedge core_clk);
            {chip_enable, loop_locked} <= cl[j];
            apb(1'b1, ra(IDX_MODES), mv[j]);
            @(posedge core_clk);
            #1;
            check("path", 32'(path_ctl), 32'(pe[j]));
        end
        apb(1'b1, ra(IDX_BIAS), 24'h1054C3);
        apb(1'b1, ra(IDX_CAL), 24'h000AB2);
        @(posedge core_clk);
        #1;
        check("bias", 32'(path_ctl.ext_bias), 32'h2);
        check("cal", 32'(calibration_value), 32'h000AB2);
        apb(1'b0, 12'h054, 24'h0);
        check("unmapped", {31'h0, err} + rd, 32'h1);
        apb(1'b1, 12'h065, 24'h0);
        apb(1'b0, ra(IDX_CAL), 24'h0);
        check("misaligned", rd, 32'h000AB2);
        apb(1'b1, ra(IDX_SEED), 24'h123456);
        @(posedge core_clk);
        freq_change <= 1'b1;
        @(posedge core_clk);
        freq_change <= 1'b0;
        #1;
        check("seed", {7'h0, seed_load, phase_seed}, 32'h01123456);
        exact_freq_mode <= 1'b1;
        apb(1'b1, ra(IDX_SEED), 24'h400000);
        repeat (3) @(posedge core_clk);
        #1;
        check("phase", 32'(phase_seed), 32'h400000);
        end_of_test();
    end
endmodule : test_synth_output_config_regs
